//--- fine_dac_core.sv
// Fourteen-bit fine DAC: operative latch, compare and stretch
`timescale 1ns/100ps
module fine_dac_core #(
    parameter int DELAY = 2
) (
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic                 step,
    input  wire logic [13:0]          count,
    input  pwm_dac_pkg::fine_cfg_t    cfg,
    input  wire logic                 hold,
    output logic                      wave
);
    import pwm_dac_pkg::*;

    if (DELAY < DELAY_NONE || DELAY > DELAY_TWO) begin : g_bad
        $error("fine_dac_core delay out of range");
    end

    // Minor value bit k stretches when upper counter half ends in 1 0..0
    function automatic logic stretch_hit(input logic [6:0] v,
                                         input logic [6:0] u);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < HALF_W; k++) begin
            if (v[k] && ((u & (7'h7F >> k)) == (7'h40 >> k))) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    logic [CNT_W-1:0] latch_q;    // Operative value
    logic             stretch_q;  // One extra high clock owed
    logic [DELAY:0]   line_q;     // Output flop then delay stages
    wire              wrap7;      // Seven low counter bits at zero
    wire              match;      // Major value equals minor counter
    wire              term;       // ORed stretch terms
    wire              load;       // Copy programmed value

    assign wrap7 = (count[6:0] == 7'h00);
    assign match = (count[6:0] == latch_q[13:7]);
    assign term  = stretch_hit(latch_q[6:0], count[13:7]);
    assign load  = step && wrap7 && !hold;

    // Load at the wrap unless a low byte waits for its high byte
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            latch_q <= '0;
        end else if (load) begin
            latch_q <= cfg.value;
        end
    end

    // Output flop; disabled channel stays released
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            line_q    <= '1;
            stretch_q <= 1'b0;
        end else if (step) begin
            if (!cfg.enable) begin
                line_q[0] <= 1'b1;
                stretch_q <= 1'b0;
            end else if (stretch_q) begin
                line_q[0] <= wrap7;
                stretch_q <= 1'b0;
            end else if (match && term) begin
                // Hold high, also when the match falls on the wrap
                line_q[0] <= 1'b1;
                stretch_q <= 1'b1;
            end else if (match) begin
                line_q[0] <= 1'b0;
            end else if (wrap7) begin
                line_q[0] <= 1'b1;
            end
            for (int i = 1; i <= DELAY; i++) begin
                line_q[i] <= line_q[i-1];
            end
        end
    end

    assign wave = line_q[DELAY];

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    hold_latch_a: assert property (
        step && wrap7 && hold |=> $stable(latch_q))
        else $error("operative latch loaded during split write");
    wrap_load_a: assert property (
        step && wrap7 && !hold |=> latch_q == $past(cfg.value))
        else $error("operative latch missed the wrap");
    fine_set_a: assert property (
        step && wrap7 && cfg.enable && !match && !stretch_q
        |=> line_q[0])
        else $error("fine output not set at wrap");
    stretch_one_a: assert property (
        step && cfg.enable && match && term && !wrap7 && !stretch_q
        && count[6:0] != 7'h7F
        |=> line_q[0] ##4 (!line_q[0] || !$past(cfg.enable)))
        else $error("stretch not exactly one PWM clock");
    fine_off_a: assert property (
        !cfg.enable [*8] ##1 !cfg.enable [*8] |-> wave)
        else $error("disabled fine output not released");

    cover_stretch_c: cover property (step && match && term);

endmodule

//--- pin_pullup_model.sv
// Pull-ups and integrator standing at the open-drain DAC pins
`timescale 1ns/100ps
module pin_pullup_model (
    input  wire logic       clk,
    input  wire logic       integ_on,
    input  wire logic [7:0] ch_oe,
    input  wire logic [7:0] ch_out,
    input  wire logic       fine_oe,
    input  wire logic       fine_out,
    output logic      [7:0] ch_pin,
    output logic            fine_pin,
    output int              fine_high
);
    // Released pins float up to the pull-up level
    assign ch_pin   = (ch_oe & ch_out) | ~ch_oe;
    assign fine_pin = fine_oe ? fine_out : 1'b1;

    // Integrator: counts core cycles the fine pin spends high
    always @(posedge clk) begin
        if (!integ_on) begin
            fine_high <= 0;
        end else if (fine_pin) begin
            fine_high <= fine_high + 1;
        end
    end
endmodule

//--- pwm_chan.sv
// Six-bit pulse-width channel with optional edge delay
`timescale 1ns/100ps
module pwm_chan #(
    parameter int DELAY = 0
) (
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic                 step,
    input  wire logic [5:0]           count_low,
    input  pwm_dac_pkg::chan_cfg_t    cfg,
    output logic                      raw,
    output logic                      wave
);
    import pwm_dac_pkg::*;

    // Only three delay groups exist
    if (DELAY < DELAY_NONE || DELAY > DELAY_TWO) begin : g_bad
        $error("pwm_chan delay out of range");
    end

    logic [DELAY:0] line_q;  // Output flop then delay stages
    wire            wrap;    // Six low counter bits at zero
    wire            match;   // Duty value equals counter

    assign wrap  = (count_low == 6'h00);
    assign match = (count_low == cfg.duty);

    // Match clears, wrap sets, clear wins when both meet
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            line_q <= '1;
        end else if (step) begin
            if (match) begin
                line_q[0] <= 1'b0;
            end else if (wrap) begin
                line_q[0] <= 1'b1;
            end
            for (int i = 1; i <= DELAY; i++) begin
                line_q[i] <= line_q[i-1];
            end
        end
    end

    assign raw  = line_q[0];
    assign wave = line_q[DELAY];

endmodule

//--- pwm_dac_bank.sv
// Eight coarse PWM DAC channels and one fine DAC on a shared counter
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps

module pwm_dac_bank #(
    parameter int NUM_CH = 8
) (
    input  wire logic                              CORE_CLK,
    input  wire logic                              ARST_N,
    input  wire logic [pwm_dac_pkg::BYTE_W-1:0]    ADDR,
    input  wire logic [pwm_dac_pkg::BYTE_W-1:0]    WR_DATA,
    input  wire logic                              WR_EN,
    input  wire logic                              RD_EN,
    output logic      [pwm_dac_pkg::BYTE_W-1:0]    RD_DATA,
    input  wire logic [pwm_dac_pkg::NUM_CH-1:0]    PORT_LATCH,
    input  wire logic                              FINE_PORT_LATCH,
    input  wire logic [pwm_dac_pkg::NUM_CH-1:0]    CH_PIN_IN,
    output logic      [pwm_dac_pkg::NUM_CH-1:0]    CH_PIN_OUT,
    output logic      [pwm_dac_pkg::NUM_CH-1:0]    CH_PIN_OE,
    input  wire logic                              FINE_PIN_IN,
    output logic                                   FINE_PIN_OUT,
    output logic                                   FINE_PIN_OE
);
    import pwm_dac_pkg::*;

    // Register map and pin widths are fixed at eight channels
    if (NUM_CH != pwm_dac_pkg::NUM_CH) begin : g_bad
        $error("pwm_dac_bank supports exactly eight channels");
    end

    // Prescaler and shared counter
    logic [1:0]       pre_q;     // Core clock divider
    logic [CNT_W-1:0] cnt_q;     // Shared counter
    logic             step_q;    // One pulse after each count
    wire              tick;      // Last core clock of a PWM clock

    // Register storage
    chan_cfg_t        ch_cfg_q [NUM_CH];  // Coarse channel settings
    logic [7:0]       low_q;              // Low byte as written
    logic             fine_en_q;          // Fine enable
    logic [5:0]       high_val_q;         // Top six value bits
    logic             pend_q;             // Low byte awaits high byte
    fine_cfg_t        fine_cfg;           // Programmed fine settings
    logic [CNT_W-1:0] fine_value;         // Unscrambled fourteen bits

    // Pin input synchroniser
    logic [PIN_CNT-1:0] pin_s1_q;   // First stage
    logic [PIN_CNT-1:0] pin_s2_q;   // Second stage
    logic [PIN_CNT-1:0] pin_s3_q;   // Third stage
    logic [PIN_CNT-1:0] pin_lvl_q;  // Accepted level
    wire  [PIN_CNT-1:0] pin_raw;    // Pins gathered

    // Waveforms and pin drive
    logic [NUM_CH-1:0] ch_raw;      // Undelayed coarse flops
    logic [NUM_CH-1:0] ch_wave;     // Delayed coarse outputs
    logic              fine_wave;   // Delayed fine output
    wire  [NUM_CH-1:0] ch_pull;     // Coarse pins pulled low
    wire               fine_pull;   // Fine pin pulled low

    // Bus decode
    wire               wr_low;      // Write to low byte
    wire               wr_high;     // Write to high byte
    wire  [NUM_CH-1:0] wr_ch;       // Write to a channel register
    wire  [7:0]        ch_off;      // Offset into channel block
    wire               ch_hit;      // Address inside channel block
    wire  [7:0]        ch_rd;       // Selected channel read value
    wire  [7:0]        high_rd;     // High byte read value
    wire  [7:0]        stat_rd;     // Fine status read value
    wire  [7:0]        rd_d;        // Read data next

    // Divide the core clock by four
    assign tick = (pre_q == PRE_LAST);

    // Prescaler, shared counter and step pulse
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pre_q  <= 2'h0;
            cnt_q  <= '0;
            step_q <= 1'b0;
        end else begin
            pre_q  <= pre_q + 2'h1;
            step_q <= tick;
            if (tick) begin
                cnt_q <= cnt_q + 14'h0001;
            end
        end
    end

    // Write decode for fine bytes and each channel register
    assign wr_low  = WR_EN && (ADDR == ADDR_FINE_LOW);
    assign wr_high = WR_EN && (ADDR == ADDR_FINE_HIGH);
    for (genvar i = 0; i < NUM_CH; i++) begin : g_wdec
        assign wr_ch[i] = WR_EN && (ADDR == ADDR_CH_BASE + 8'(i));
    end

    // Channel registers; enables clear at reset
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ch_cfg_q[i] <= chan_cfg_t'(CH_RESET[6:0]);
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (wr_ch[i]) begin
                    ch_cfg_q[i].enable <= WR_DATA[EN_BIT];
                    ch_cfg_q[i].duty   <= WR_DATA[5:0];
                end
            end
        end
    end

    // Fine bytes and split-write tracking
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            low_q      <= FINE_LOW_RESET;
            fine_en_q  <= FINE_HIGH_RESET[EN_BIT];
            high_val_q <= FINE_HIGH_RESET[5:0];
            pend_q     <= 1'b0;
        end else begin
            if (wr_low) begin
                low_q  <= WR_DATA;
                pend_q <= 1'b1;
            end
            if (wr_high) begin
                fine_en_q  <= WR_DATA[EN_BIT];
                high_val_q <= WR_DATA[5:0];
                pend_q     <= 1'b0;
            end
        end
    end

    // Low byte holds bit seven on top, bits zero to six reversed
    assign fine_value[CNT_W-1:8]  = high_val_q;
    assign fine_value[LOW_TOP_BIT] = low_q[LOW_TOP_BIT];
    for (genvar k = 0; k < HALF_W; k++) begin : g_swz
        assign fine_value[k] = low_q[6-k];
    end
    // Value passes straight through; no inversion path exists
    assign fine_cfg.value  = fine_value;
    assign fine_cfg.enable = fine_en_q;

    // Coarse channels in three delay groups
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        pwm_chan #(
            .DELAY (chan_delay(i))
        ) u_chan (
            .clk       (CORE_CLK),
            .arst_n    (ARST_N),
            .step      (step_q),
            .count_low (cnt_q[DUTY_W-1:0]),
            .cfg       (ch_cfg_q[i]),
            .raw       (ch_raw[i]),
            .wave      (ch_wave[i])
        );
    end

    // Fine channel in the two-clock group
    fine_dac_core #(
        .DELAY (FINE_DELAY)
    ) u_fine (
        .clk    (CORE_CLK),
        .arst_n (ARST_N),
        .step   (step_q),
        .count  (cnt_q),
        .cfg    (fine_cfg),
        .hold   (pend_q),
        .wave   (fine_wave)
    );

    // Pin ownership and wired-AND of the fine pin
    for (genvar i = 0; i < NUM_CH; i++) begin : g_own
        assign ch_pull[i] = ch_cfg_q[i].enable ? !ch_wave[i]
                                               : !PORT_LATCH[i];
    end
    assign fine_pull = !FINE_PORT_LATCH || !fine_wave;

    // Open-drain drive: output low, enable while pulling
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CH_PIN_OUT   <= '0;
            CH_PIN_OE    <= '0;
            FINE_PIN_OUT <= 1'b0;
            FINE_PIN_OE  <= 1'b0;
        end else begin
            CH_PIN_OUT   <= '0;
            CH_PIN_OE    <= ch_pull;
            FINE_PIN_OUT <= 1'b0;
            FINE_PIN_OE  <= fine_pull;
        end
    end

    // Pin levels settle once the second and third stages agree
    assign pin_raw = {FINE_PIN_IN, CH_PIN_IN};
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_s1_q  <= '1;
            pin_s2_q  <= '1;
            pin_s3_q  <= '1;
            pin_lvl_q <= '1;
        end else begin
            pin_s1_q  <= pin_raw;
            pin_s2_q  <= pin_s1_q;
            pin_s3_q  <= pin_s2_q;
            pin_lvl_q <= (pin_s2_q & pin_s3_q)
                       | ((pin_s2_q ^ pin_s3_q) & pin_lvl_q);
        end
    end

    // Read decode; reserved bits read zero
    assign ch_off  = ADDR - ADDR_CH_BASE;
    assign ch_hit  = (ADDR >= ADDR_CH_BASE) && (ch_off < 8'(NUM_CH));
    assign ch_rd   = {ch_cfg_q[ch_off[2:0]].enable, 1'b0,
                      ch_cfg_q[ch_off[2:0]].duty};
    assign high_rd = {fine_en_q, 1'b0, high_val_q};
    assign stat_rd = {5'h00, fine_wave, pend_q,
                      pin_lvl_q[PIN_CNT-1]};
    assign rd_d    = (ADDR == ADDR_FINE_LOW)  ? low_q :
                     (ADDR == ADDR_FINE_HIGH) ? high_rd :
                     ch_hit                   ? ch_rd :
                     (ADDR == ADDR_PIN_STATE) ? pin_lvl_q[NUM_CH-1:0] :
                     (ADDR == ADDR_FINE_STAT) ? stat_rd :
                                                8'h00;

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RD_DATA <= 8'h00;
        end else begin
            RD_DATA <= RD_EN ? rd_d : 8'h00;
        end
    end

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);

    prescale_four_a: assert property (
        tick |=> !tick [*3] ##1 tick)
        else $error("PWM clock is not core clock over four");
    count_step_a: assert property (
        tick |=> cnt_q == 14'($past(cnt_q) + 14'h0001))
        else $error("shared counter did not advance");
    chan_match_a: assert property (
        step_q && cnt_q[5:0] == ch_cfg_q[0].duty |=> !ch_wave[0])
        else $error("channel output not cleared on match");
    chan_wrap_a: assert property (
        step_q && cnt_q[5:0] == 6'h00 && ch_cfg_q[0].duty != 6'h00
        |=> ch_wave[0])
        else $error("channel output not set at wrap");
    delay_one_a: assert property (
        step_q |=> ch_wave[3] == $past(ch_raw[3]))
        else $error("one-clock group edge misplaced");
    delay_two_a: assert property (
        step_q |=> ch_wave[6] == $past(ch_raw[6], 5))
        else $error("two-clock group edge misplaced");
    pin_owner_a: assert property (
        !ch_cfg_q[1].enable |=> CH_PIN_OE[1] == !$past(PORT_LATCH[1]))
        else $error("port latch lost pin ownership");
    wired_and_a: assert property (
        1'b1 |=> FINE_PIN_OE == $past(!FINE_PORT_LATCH || !fine_wave))
        else $error("fine pin not wired-AND with port latch");
    split_hold_a: assert property (
        wr_low ##1 !wr_high [*2] |-> pend_q)
        else $error("split write not held pending");
    low_swizzle_a: assert property (
        wr_low |=> fine_value[0] == $past(WR_DATA[6])
                && fine_value[6] == $past(WR_DATA[0]))
        else $error("low byte bit order wrong");

    cover_enable_c: cover property (wr_ch[0] && WR_DATA[EN_BIT]);
    cover_split_c:  cover property (wr_low ##[1:20] wr_high);
    cover_fine_c:   cover property (fine_en_q && $fell(fine_wave));

endmodule

//--- pwm_dac_pkg.sv
// Shared constants and carrier types for the PWM DAC bank
package pwm_dac_pkg;

    // Widths
    localparam int BYTE_W    = 8;   // Register and port width
    localparam int CNT_W     = 14;  // Shared counter width
    localparam int DUTY_W    = 6;   // Coarse channel duty width
    localparam int HALF_W    = 7;   // Major and minor halves of fine value
    localparam int NUM_CH    = 8;   // Coarse channels
    localparam int PIN_CNT   = 9;   // Coarse pins plus the fine pin

    // PWM clock is the core clock divided by four
    localparam int              PRESCALE   = 4;
    localparam logic [1:0]      PRE_LAST   = 2'(PRESCALE - 1);

    // Register offsets
    localparam logic [7:0] ADDR_FINE_LOW  = 8'hD2;
    localparam logic [7:0] ADDR_FINE_HIGH = 8'hD3;
    localparam logic [7:0] ADDR_CH_BASE   = 8'hD4;
    localparam logic [7:0] ADDR_PIN_STATE = 8'hDC;
    localparam logic [7:0] ADDR_FINE_STAT = 8'hDD;

    // Field positions
    localparam int EN_BIT      = 7;  // Enable in channel and high byte
    localparam int LOW_TOP_BIT = 7;  // Value bit seven in the low byte
    localparam int ST_PIN_BIT  = 0;  // Fine pin level in fine status
    localparam int ST_PEND_BIT = 1;  // Load pending in fine status
    localparam int ST_WAVE_BIT = 2;  // Fine waveform in fine status

    // Reset values
    localparam logic [7:0] CH_RESET        = 8'h00;
    localparam logic [7:0] FINE_LOW_RESET  = 8'h00;
    localparam logic [7:0] FINE_HIGH_RESET = 8'h00;

    // Edge delay groups, in PWM clocks
    localparam int DELAY_NONE = 0;
    localparam int DELAY_ONE  = 1;
    localparam int DELAY_TWO  = 2;
    localparam int FINE_DELAY = DELAY_TWO;

    // Coarse channel settings
    typedef struct packed {
        logic              enable;
        logic [DUTY_W-1:0] duty;
    } chan_cfg_t;

    // Fine channel settings
    typedef struct packed {
        logic             enable;
        logic [CNT_W-1:0] value;
    } fine_cfg_t;

    // Edge delay of a coarse channel by its index
    function automatic int chan_delay(input int idx);
        if (idx < 3) begin
            return DELAY_NONE;
        end
        if (idx < 6) begin
            return DELAY_ONE;
        end
        return DELAY_TWO;
    endfunction

endpackage

//--- tb_pwm_dac_bank.sv
// Self-checking bench for the PWM DAC bank
`timescale 1ns/100ps
module tb_pwm_dac_bank;
    import pwm_dac_pkg::*;
    logic        core_clk   = 1'b0;   // 40 MHz core clock
    logic        arst_n     = 1'b0;   // Reset, active low
    logic [7:0]  addr       = 8'h00;  // Register address
    logic [7:0]  wr_data    = 8'h00;  // Write data
    logic        wr_en      = 1'b0;   // Write strobe
    logic        rd_en      = 1'b0;   // Read strobe
    logic [7:0]  port_latch = 8'hA5;  // Port latch of coarse pins
    logic        fine_latch = 1'b0;   // Port latch of the fine pin
    logic        integ_on   = 1'b0;   // Integrator window
    logic [7:0]  rd_data, ch_pin, ch_out, ch_oe, lowb;
    logic        fine_pin, fine_out, fine_oe;
    logic [13:0] val;
    int          fine_high, hi_cnt[8], fall_at[8];
    int          num_errors  = 0;
    int          checks_done = 0;

    // Core clock, 25 ns period
    always #12.5 core_clk = ~core_clk;

    pwm_dac_bank dut (.CORE_CLK(core_clk), .ARST_N(arst_n), .ADDR(addr),
        .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data),
        .PORT_LATCH(port_latch), .FINE_PORT_LATCH(fine_latch),
        .CH_PIN_IN(ch_pin), .CH_PIN_OUT(ch_out), .CH_PIN_OE(ch_oe),
        .FINE_PIN_IN(fine_pin), .FINE_PIN_OUT(fine_out),
        .FINE_PIN_OE(fine_oe));

    pin_pullup_model pins (.clk(core_clk), .integ_on(integ_on),
        .ch_oe(ch_oe), .ch_out(ch_out), .fine_oe(fine_oe),
        .fine_out(fine_out), .ch_pin(ch_pin), .fine_pin(fine_pin),
        .fine_high(fine_high));

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %0h expected %0h",
                     $time, got, exp);
        end
    endtask

    // One-cycle write, then one idle cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
        @(posedge core_clk);
    endtask

    // One-cycle read; data looked at in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                      input logic [7:0] mask = 8'hFF);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        chk(rd_data & mask, exp);
        @(posedge core_clk);
    endtask

    // High time and first falling edge of each coarse pin
    task automatic measure();
        logic [7:0] prev;
        #1;
        prev = ch_pin;
        for (int i = 0; i < 8; i++) begin
            hi_cnt[i]  = 0;
            fall_at[i] = -1;
        end
        for (int c = 0; c < 264; c++) begin
            @(posedge core_clk);
            #1;
            for (int i = 0; i < 8; i++) begin
                if (c < 256) hi_cnt[i] += int'(ch_pin[i]);
                if (prev[i] && !ch_pin[i] && fall_at[i] < 0 &&
                    (i == 0 || fall_at[0] >= 0)) fall_at[i] = c;
            end
            prev = ch_pin;
        end
        @(posedge core_clk);
    endtask

    // Fine pin high time over n core cycles
    task automatic integ(input int n, input logic [31:0] exp);
        integ_on <= 1'b1;
        repeat (n) @(posedge core_clk);
        integ_on <= 1'b0;
        #1;
        chk(fine_high, exp);
        @(posedge core_clk);
    endtask

    // Counts, verdict, end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        // Pins left to the port latches after reset
        chk(ch_oe, 8'h5A);
        chk(fine_oe, 1'b1);
        chk(ch_out, 8'h00);
        chk(fine_out, 1'b0);
        port_latch <= 8'hFF;
        fine_latch <= 1'b1;
        rd(ADDR_FINE_LOW, 8'h00);
        rd(ADDR_FINE_HIGH, 8'h00);
        for (int i = 0; i < 8; i++) rd(8'(ADDR_CH_BASE + i), 8'h00);
        rd(8'hE0, 8'h00);
        rd(ADDR_PIN_STATE, 8'hFF);
        #1;
        chk(rd_data, 8'h00);
        @(posedge core_clk);
        $display("test reset done");
        // Field layout, reserved bits and split fine load
        wr(8'(ADDR_CH_BASE + 7), 8'hFF);
        rd(8'(ADDR_CH_BASE + 7), 8'hBF);
        wr(ADDR_FINE_HIGH, 8'h7F);
        rd(ADDR_FINE_HIGH, 8'h3F);
        wr(ADDR_FINE_LOW, 8'hA5);
        rd(ADDR_FINE_LOW, 8'hA5);
        rd(ADDR_FINE_STAT, 8'h02, 8'h02);
        wr(ADDR_FINE_HIGH, 8'h00);
        rd(ADDR_FINE_STAT, 8'h00, 8'h02);
        $display("test registers done");
        // Same duty on all channels: edge delay groups
        for (int i = 0; i < 8; i++) wr(8'(ADDR_CH_BASE + i), 8'h8A);
        repeat (300) @(posedge core_clk);
        measure();
        for (int i = 0; i < 8; i++) begin
            chk(hi_cnt[i], 40);
            chk(fall_at[i] - fall_at[0], (i < 3) ? 0 : (i < 6) ? 4 : 8);
        end
        $display("test delay groups done");
        // Duty sweep from 0 to 63
        for (int i = 0; i < 8; i++) wr(8'(ADDR_CH_BASE + i), 8'h80 | 8'(i * 9));
        repeat (300) @(posedge core_clk);
        measure();
        for (int i = 0; i < 8; i++) chk(hi_cnt[i], i * 36);
        // Disabled channel hands its pin back to the port
        wr(8'(ADDR_CH_BASE + 2), 8'h3F);
        measure();
        chk(hi_cnt[2], 256);
        chk(hi_cnt[1], 36);
        $display("test duty sweep done");
        // Fine DAC over one whole counter cycle
        val     = 14'h2A5B;
        lowb[7] = val[7];
        for (int k = 0; k < 7; k++) lowb[6 - k] = val[k];
        wr(ADDR_FINE_LOW, lowb);
        wr(ADDR_FINE_HIGH, {2'b10, val[13:8]});
        repeat (600) @(posedge core_clk);
        integ(65536, 4 * int'(val));
        fine_latch <= 1'b0;
        repeat (4) @(posedge core_clk);
        integ(512, 0);
        fine_latch <= 1'b1;
        wr(ADDR_FINE_HIGH, {2'b00, val[13:8]});
        repeat (20) @(posedge core_clk);
        integ(512, 512);
        $display("test fine dac done");
        test_done();
    end
endmodule
